// File: rtl/pdarc_top.sv
// spi-reached register group steering lvds output buffers, global
// power-down of clock buffer / reference amplifier / bandgap, the shared
// alignment / power-down pin, and reference and clock source selection
// assumes spi pins and the two control pins are asynchronous to clock_i;
// output_lane_mode_i comes from logic on clock_i
//
// Behaviour
// RL1 - frame clock buffer off when bit 5
// RL2 - bit clock buffer off when bit 4
// RL3 - lane A1 off by bit, one/half lane
// RL4 - lane A0 off by bit 2, reset 1
// RL5 - lane B1 off by bit, one/half lane
// RL6 - lane B0 off by bit, half lane
// RL7 - mask bit 3 keeps clock buffer on
// RL8 - mask bit 2 keeps reference amp on
// RL9 - mask bit 1 switches bandgap off too
// RL10 - bit 7 picks pin: power-down or align
// RL11 - bit 6 rising issues alignment when enabled
// RL12 - host clears trigger before next alignment
// RL13 - bit 5 moves alignment from pin to register
// RL14 - bit 3 picks pin or register control
// RL15 - reference option field decode, two bits
// RL16 - bit 0 selects single-ended clock input
// RL17 - main power bit 0 requests global power-down
// RL18 - lane mode drives automatic lane shutdown
// RL19 - global power-down from register or pin
// RL20 - host writes zero to reserved bits
`timescale 1ns/1ps

`include "pdarc_defs.svh"

module pdarc_top (
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic       spi_sclk_i,
    input  wire logic       spi_sen_n_i,
    input  wire logic       spi_sdi_i,
    output logic            spi_sdo_o,
    output logic            spi_sdo_oe_n_o,
    input  wire logic       shared_align_powerdown_pin_i,
    input  wire logic       reference_buffer_pin_i,
    input  wire logic [2:0] output_lane_mode_i,
    output logic            frame_clock_out_powerdown_o,
    output logic            bit_clock_out_powerdown_o,
    output logic            lane_a1_powerdown_o,
    output logic            lane_a0_powerdown_o,
    output logic            lane_b1_powerdown_o,
    output logic            lane_b0_powerdown_o,
    output logic            global_powerdown_o,
    output logic            clock_buffer_powerdown_o,
    output logic            reference_amp_powerdown_o,
    output logic            bandgap_powerdown_o,
    output logic            align_command_o,
    output logic [1:0]      reference_option_o,
    output logic            single_ended_clock_select_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pin_meta_r;
    logic [4:0] pin_sync_r;
    logic [4:0] pin_dly_r;
    logic [4:0] pin_raw;

    assign pin_raw = {reference_buffer_pin_i, shared_align_powerdown_pin_i,
                      spi_sdi_i, spi_sen_n_i, spi_sclk_i};

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            pin_meta_r <= 5'h06;
            pin_sync_r <= 5'h06;
            pin_dly_r  <= 5'h06;
        end else begin
            pin_meta_r <= pin_raw;
            pin_sync_r <= pin_meta_r;
            pin_dly_r  <= pin_sync_r;
        end
    end

    wire sclk_s      = pin_sync_r[0];
    wire sen_n_s     = pin_sync_r[1];
    wire sdi_s       = pin_sync_r[2];
    wire shared_pin  = pin_sync_r[3];
    wire ref_pin     = pin_sync_r[4];
    wire sclk_rise   = sclk_s & ~pin_dly_r[0];
    wire sclk_fall   = ~sclk_s & pin_dly_r[0];
    wire shared_rise = shared_pin & ~pin_dly_r[3];

    // ------------------------------------------------------------
    // spi frame sequencer
    // ------------------------------------------------------------
    pdarc_pkg::pdarc_spi_state_t state_r;
    pdarc_pkg::pdarc_spi_state_t state_nxt;
    logic [4:0]                  bit_cnt_r;
    logic [14:0]                 shift_r;
    logic                        rd_flag_r;
    pdarc_pkg::pdarc_addr_t      addr_r;
    pdarc_pkg::pdarc_reg_t       tx_r;
    logic                        sdo_r;
    logic                        sdo_en_r;

    wire                         hdr_done  = sclk_rise && (bit_cnt_r == `PDARC_SPI_HDR_LAST);
    wire                         frame_end = sclk_rise && (bit_cnt_r == `PDARC_SPI_FRAME_LAST);
    wire pdarc_pkg::pdarc_addr_t hdr_addr  = {shift_r[5:0], sdi_s};

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pdarc_pkg::PDARC_SPI_IDLE: begin
                if (!sen_n_s) begin
                    state_nxt = pdarc_pkg::PDARC_SPI_HEADER;
                end
            end
            pdarc_pkg::PDARC_SPI_HEADER: begin
                if (hdr_done) begin
                    state_nxt = pdarc_pkg::PDARC_SPI_DATA;
                end
            end
            pdarc_pkg::PDARC_SPI_DATA: begin
                if (frame_end) begin
                    state_nxt = pdarc_pkg::PDARC_SPI_HEADER;
                end
            end
            default: begin
                state_nxt = pdarc_pkg::PDARC_SPI_IDLE;
            end
        endcase
        if (sen_n_s) begin
            state_nxt = pdarc_pkg::PDARC_SPI_IDLE;
        end
    end

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    pdarc_pkg::pdarc_reg_t main_power_r;
    pdarc_pkg::pdarc_reg_t lvds_output_powerdown_r;
    pdarc_pkg::pdarc_reg_t global_powerdown_mask_r;
    pdarc_pkg::pdarc_reg_t align_reference_clock_config_r;

    wire                        wr_en    = frame_end && (state_r == pdarc_pkg::PDARC_SPI_DATA)
                                           && !rd_flag_r;
    wire pdarc_pkg::pdarc_reg_t wr_data  = {shift_r[6:0], sdi_s};
    wire                        wr_main  = wr_en && (addr_r == `PDARC_OFS_MAIN_POWER);
    wire                        wr_lvds  = wr_en && (addr_r == `PDARC_OFS_LVDS_OUT_PD);
    wire                        wr_mask  = wr_en && (addr_r == `PDARC_OFS_GLOBAL_PD_MASK);
    wire                        wr_cfg   = wr_en && (addr_r == `PDARC_OFS_ALIGN_REF_CFG);

    // unmapped addresses read as zero
    wire pdarc_pkg::pdarc_reg_t rd_data  =
        (hdr_addr == `PDARC_OFS_MAIN_POWER)     ? main_power_r :
        (hdr_addr == `PDARC_OFS_LVDS_OUT_PD)    ? lvds_output_powerdown_r :
        (hdr_addr == `PDARC_OFS_GLOBAL_PD_MASK) ? global_powerdown_mask_r :
        (hdr_addr == `PDARC_OFS_ALIGN_REF_CFG)  ? align_reference_clock_config_r :
        8'h00;

    // reserved bits keep their reset value whatever the host sends
    function automatic pdarc_pkg::pdarc_reg_t merge(input pdarc_pkg::pdarc_reg_t rst,
                                                    input pdarc_pkg::pdarc_reg_t msk,
                                                    input pdarc_pkg::pdarc_reg_t val);
        merge = (val & msk) | (rst & ~msk);
    endfunction

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            state_r   <= pdarc_pkg::PDARC_SPI_IDLE;
            bit_cnt_r <= 5'h00;
            shift_r   <= 15'h0000;
            rd_flag_r <= 1'b0;
            addr_r    <= 7'h00;
            tx_r      <= 8'h00;
            sdo_r     <= 1'b0;
            sdo_en_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (sen_n_s) begin
                bit_cnt_r <= 5'h00;
                sdo_en_r  <= 1'b0;
            end else begin
                if (sclk_rise) begin
                    shift_r   <= {shift_r[13:0], sdi_s};
                    bit_cnt_r <= frame_end ? 5'h00 : (bit_cnt_r + 5'h01);
                end
                if (hdr_done) begin
                    rd_flag_r <= shift_r[6];
                    addr_r    <= hdr_addr;
                    tx_r      <= rd_data;
                end
                if (frame_end) begin
                    sdo_en_r <= 1'b0;
                end else if (sclk_fall && (state_r == pdarc_pkg::PDARC_SPI_DATA)
                             && rd_flag_r) begin
                    sdo_r    <= tx_r[7];
                    tx_r     <= {tx_r[6:0], 1'b0};
                    sdo_en_r <= 1'b1;
                end
            end
        end
    end

    assign spi_sdo_o      = sdo_r;
    assign spi_sdo_oe_n_o = ~sdo_en_r;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            main_power_r                   <= `PDARC_RST_MAIN_POWER;
            lvds_output_powerdown_r        <= `PDARC_RST_LVDS_OUT_PD;
            global_powerdown_mask_r        <= `PDARC_RST_GLOBAL_PD_MASK;
            align_reference_clock_config_r <= `PDARC_RST_ALIGN_REF_CFG;
        end else begin
            if (wr_main) begin
                main_power_r <= merge(`PDARC_RST_MAIN_POWER, `PDARC_WMSK_MAIN_POWER, wr_data);
            end
            if (wr_lvds) begin
                lvds_output_powerdown_r <= merge(`PDARC_RST_LVDS_OUT_PD,
                                                 `PDARC_WMSK_LVDS_OUT_PD, wr_data);
            end
            if (wr_mask) begin
                global_powerdown_mask_r <= merge(`PDARC_RST_GLOBAL_PD_MASK,
                                                 `PDARC_WMSK_GLOBAL_PD_MASK, wr_data);
            end
            if (wr_cfg) begin
                align_reference_clock_config_r <= merge(`PDARC_RST_ALIGN_REF_CFG,
                                                        `PDARC_WMSK_ALIGN_REF_CFG, wr_data);
            end
        end
    end

    // ------------------------------------------------------------
    // power-down, alignment and reference decode
    // ------------------------------------------------------------
    wire [7:0] cfg      = align_reference_clock_config_r;
    wire [7:0] outpd    = lvds_output_powerdown_r;
    wire [7:0] msk      = global_powerdown_mask_r;
    wire       one_lane = (output_lane_mode_i == `PDARC_LANE_MODE_ONE);
    wire       half_lane = (output_lane_mode_i == `PDARC_LANE_MODE_HALF);
    wire       pin_align_mode = cfg[`PDARC_BIT_PIN_IS_ALIGN];
    wire       reg_align_en   = cfg[`PDARC_BIT_REG_ALIGN_EN];
    wire       ref_ctrl_reg   = cfg[`PDARC_BIT_REF_CTRL_SRC];
    logic      trig_dly_r;

    // RL17 RL19 RL10 register or pin power-down
    wire gpd = main_power_r[`PDARC_BIT_GLOBAL_PD_CTRL] | (~pin_align_mode & shared_pin);

    // RL11 RL13 register trigger edge
    wire reg_align = reg_align_en & cfg[`PDARC_BIT_REG_ALIGN_TRIG] & ~trig_dly_r;
    // RL10 RL13 pin alignment edge
    wire pin_align = pin_align_mode & ~reg_align_en & shared_rise;

    // RL16 single-ended clock select
    wire se_clk = ref_ctrl_reg & cfg[`PDARC_BIT_SE_CLK_SEL];

    // RL14 RL15 reference source and option
    wire [1:0] ref_opt = ref_ctrl_reg ?
                         cfg[`PDARC_MSB_REF_OPTION:`PDARC_LSB_REF_OPTION] :
                         (ref_pin ? `PDARC_REF_EXT_BUFFERED : `PDARC_REF_INTERNAL);

    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            trig_dly_r                  <= 1'b0;
            frame_clock_out_powerdown_o <= 1'b0;
            bit_clock_out_powerdown_o   <= 1'b0;
            lane_a1_powerdown_o         <= 1'b1;
            lane_a0_powerdown_o         <= 1'b1;
            lane_b1_powerdown_o         <= 1'b0;
            lane_b0_powerdown_o         <= 1'b0;
            global_powerdown_o          <= 1'b0;
            clock_buffer_powerdown_o    <= 1'b0;
            reference_amp_powerdown_o   <= 1'b0;
            bandgap_powerdown_o         <= 1'b0;
            align_command_o             <= 1'b0;
            reference_option_o          <= 2'h0;
            single_ended_clock_select_o <= 1'b0;
        end else begin
            // RL12 trigger held high issues only once
            trig_dly_r <= cfg[`PDARC_BIT_REG_ALIGN_TRIG];
            // RL1 frame clock buffer
            frame_clock_out_powerdown_o <= outpd[`PDARC_BIT_FRAME_CLK_PD];
            // RL2 bit clock buffer
            bit_clock_out_powerdown_o   <= outpd[`PDARC_BIT_BIT_CLK_PD];
            // RL3 RL18 lane a1 forced off
            lane_a1_powerdown_o <= outpd[`PDARC_BIT_LANE_A1_PD] | one_lane | half_lane;
            // RL4 lane a0 buffer
            lane_a0_powerdown_o <= outpd[`PDARC_BIT_LANE_A0_PD];
            // RL5 RL18 lane b1 forced off
            lane_b1_powerdown_o <= outpd[`PDARC_BIT_LANE_B1_PD] | one_lane | half_lane;
            // RL6 RL18 lane b0 forced off
            lane_b0_powerdown_o <= outpd[`PDARC_BIT_LANE_B0_PD] | half_lane;
            global_powerdown_o  <= gpd;
            // RL7 RL16 clock buffer off
            clock_buffer_powerdown_o  <= (gpd & ~msk[`PDARC_BIT_KEEP_CLK_BUF]) | se_clk;
            // RL8 reference amp mask
            reference_amp_powerdown_o <= gpd & ~msk[`PDARC_BIT_KEEP_REF_AMP];
            // RL9 bandgap inverted mask
            bandgap_powerdown_o <= gpd & msk[`PDARC_BIT_BANDGAP_OFF];
            align_command_o     <= reg_align | pin_align;
            reference_option_o  <= ref_opt;
            single_ended_clock_select_o <= se_clk;
        end
    end

endmodule

// File: rtl/pdarc_defs.svh
// offsets, field positions, reset values and codes of the power-down,
// alignment and reference configuration registers
// assumes inclusion by bare name from the top module, the checker and the bench
`ifndef PDARC_DEFS_SVH
`define PDARC_DEFS_SVH

// register offsets (7-bit spi address)
`define PDARC_OFS_MAIN_POWER        7'h08
`define PDARC_OFS_LVDS_OUT_PD       7'h09
`define PDARC_OFS_GLOBAL_PD_MASK    7'h0D
`define PDARC_OFS_ALIGN_REF_CFG     7'h0E

// reset values
`define PDARC_RST_MAIN_POWER        8'h02
`define PDARC_RST_LVDS_OUT_PD       8'h0C
`define PDARC_RST_GLOBAL_PD_MASK    8'h00
`define PDARC_RST_ALIGN_REF_CFG     8'h00

// writable bits; the rest read back as their reset value
`define PDARC_WMSK_MAIN_POWER       8'h35
`define PDARC_WMSK_LVDS_OUT_PD      8'h3F
`define PDARC_WMSK_GLOBAL_PD_MASK   8'h0E
`define PDARC_WMSK_ALIGN_REF_CFG    8'hEF

// main power register fields
`define PDARC_BIT_GLOBAL_PD_CTRL    0

// lvds output power-down fields
`define PDARC_BIT_FRAME_CLK_PD      5
`define PDARC_BIT_BIT_CLK_PD        4
`define PDARC_BIT_LANE_A1_PD        3
`define PDARC_BIT_LANE_A0_PD        2
`define PDARC_BIT_LANE_B1_PD        1
`define PDARC_BIT_LANE_B0_PD        0

// global power-down mask fields
`define PDARC_BIT_KEEP_CLK_BUF      3
`define PDARC_BIT_KEEP_REF_AMP      2
`define PDARC_BIT_BANDGAP_OFF       1

// alignment / reference / clock configuration fields
`define PDARC_BIT_PIN_IS_ALIGN      7
`define PDARC_BIT_REG_ALIGN_TRIG    6
`define PDARC_BIT_REG_ALIGN_EN      5
`define PDARC_BIT_REF_CTRL_SRC      3
`define PDARC_MSB_REF_OPTION        2
`define PDARC_LSB_REF_OPTION        1
`define PDARC_BIT_SE_CLK_SEL        0

// output lane mode codes
`define PDARC_LANE_MODE_ONE         3'h4
`define PDARC_LANE_MODE_HALF        3'h5

// reference option codes
`define PDARC_REF_INTERNAL          2'h0
`define PDARC_REF_EXT_BUFFERED      2'h1

// spi frame layout: read flag, 7 address bits, 8 data bits
`define PDARC_SPI_FRAME_BITS        5'h10
`define PDARC_SPI_HDR_LAST          5'h07
`define PDARC_SPI_FRAME_LAST        5'h0F

`endif

// File: rtl/pdarc_pkg.sv
// types of the power-down, alignment and reference configuration block
// assumes pdarc_defs.svh is on the include path
package pdarc_pkg;

    // spi frame sequencer, gray coded along idle -> header -> data
    typedef enum logic [1:0] {
        PDARC_SPI_IDLE   = 2'h0,
        PDARC_SPI_HEADER = 2'h1,
        PDARC_SPI_DATA   = 2'h3
    } pdarc_spi_state_t;

    typedef logic [7:0] pdarc_reg_t;
    typedef logic [6:0] pdarc_addr_t;

endpackage

// File: test/pdarc_top_checker.sv
// checker for the power-down, alignment and reference register group
// assumes binding to pdarc_top and sight of its ports only
`timescale 1ns/1ps

`include "pdarc_defs.svh"

module pdarc_top_checker (
    input wire logic       clock_i,
    input wire logic       resetn_i,
    input wire logic [2:0] output_lane_mode_i,
    input wire logic       frame_clock_out_powerdown_o,
    input wire logic       bit_clock_out_powerdown_o,
    input wire logic       lane_a1_powerdown_o,
    input wire logic       lane_a0_powerdown_o,
    input wire logic       lane_b1_powerdown_o,
    input wire logic       lane_b0_powerdown_o,
    input wire logic       global_powerdown_o,
    input wire logic       clock_buffer_powerdown_o,
    input wire logic       reference_amp_powerdown_o,
    input wire logic       bandgap_powerdown_o,
    input wire logic       align_command_o,
    input wire logic       single_ended_clock_select_o
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    property p_reset_values;
        $rose(resetn_i) |-> lane_a1_powerdown_o && lane_a0_powerdown_o && !lane_b1_powerdown_o
            && !frame_clock_out_powerdown_o && !bit_clock_out_powerdown_o
            && !global_powerdown_o && !align_command_o;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("outputs after reset differ from reset values");

    property p_narrow_lanes;
        (output_lane_mode_i == `PDARC_LANE_MODE_ONE || output_lane_mode_i == `PDARC_LANE_MODE_HALF)
            |=> lane_a1_powerdown_o && lane_b1_powerdown_o;
    endproperty
    a_narrow_lanes: assert property (p_narrow_lanes)
        else $error("lane 1 buffers left on in narrow lane mode");

    property p_half_lane;
        output_lane_mode_i == `PDARC_LANE_MODE_HALF |=> lane_b0_powerdown_o;
    endproperty
    a_half_lane: assert property (p_half_lane)
        else $error("lane b0 buffer left on in half lane mode");

    property p_align_pulse;
        $rose(align_command_o) |=> $fell(align_command_o);
    endproperty
    a_align_pulse: assert property (p_align_pulse)
        else $error("alignment command longer than one cycle");

    property p_refamp;
        reference_amp_powerdown_o |-> global_powerdown_o || $past(global_powerdown_o);
    endproperty
    a_refamp: assert property (p_refamp)
        else $error("reference amp off without global power-down");

    property p_bandgap;
        bandgap_powerdown_o |-> global_powerdown_o || $past(global_powerdown_o);
    endproperty
    a_bandgap: assert property (p_bandgap)
        else $error("bandgap off without global power-down");

    property p_clkbuf;
        clock_buffer_powerdown_o |-> global_powerdown_o || $past(global_powerdown_o)
            || single_ended_clock_select_o || $past(single_ended_clock_select_o);
    endproperty
    a_clkbuf: assert property (p_clkbuf)
        else $error("clock buffer off without cause");

    property p_se_clkbuf;
        single_ended_clock_select_o && $past(single_ended_clock_select_o)
            |-> clock_buffer_powerdown_o;
    endproperty
    a_se_clkbuf: assert property (p_se_clkbuf)
        else $error("differential clock buffer on with single-ended clock");
endmodule

bind pdarc_top pdarc_top_checker i_chk (
    .clock_i                     (clock_i),
    .resetn_i                    (resetn_i),
    .output_lane_mode_i          (output_lane_mode_i),
    .frame_clock_out_powerdown_o (frame_clock_out_powerdown_o),
    .bit_clock_out_powerdown_o   (bit_clock_out_powerdown_o),
    .lane_a1_powerdown_o         (lane_a1_powerdown_o),
    .lane_a0_powerdown_o         (lane_a0_powerdown_o),
    .lane_b1_powerdown_o         (lane_b1_powerdown_o),
    .lane_b0_powerdown_o         (lane_b0_powerdown_o),
    .global_powerdown_o          (global_powerdown_o),
    .clock_buffer_powerdown_o    (clock_buffer_powerdown_o),
    .reference_amp_powerdown_o   (reference_amp_powerdown_o),
    .bandgap_powerdown_o         (bandgap_powerdown_o),
    .align_command_o             (align_command_o),
    .single_ended_clock_select_o (single_ended_clock_select_o)
);

// File: test/pdarc_spi_host.sv
// spi host model: 16-bit frames, read flag first, mode 0
// assumes the caller keeps frames apart; sclk phases last 6 clocks
`timescale 1ns/1ps

module pdarc_spi_host (
    input  wire logic clock_i,
    output logic      spi_sclk_o,
    output logic      spi_sen_n_o,
    output logic      spi_sdi_o,
    input  wire logic spi_sdo_i,
    input  wire logic spi_sdo_oe_n_i
);
    localparam int HALF = 6;

    initial begin
        spi_sclk_o = 1'b0;
        spi_sen_n_o = 1'b1;
        spi_sdi_o = 1'b0;
    end

    // ----------------------------------------
    // one frame, whole or cut short after nb bits
    // ----------------------------------------
    // nb below 16 cuts the frame short, which the device must discard
    task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wd,
                        input int nb, output logic [7:0] rdat);
        logic [15:0] frm;
        frm = {rd, addr, wd};
        rdat = 8'h00;
        @(posedge clock_i) spi_sen_n_o <= 1'b0;
        for (int i = 15; i >= 16 - nb; i--) begin
            spi_sdi_o <= frm[i];
            repeat (HALF) @(posedge clock_i);
            // read data is taken at the edge that raises sclk
            if (i < 8) begin
                rdat = {rdat[6:0], (spi_sdo_oe_n_i === 1'b0) ? spi_sdo_i : 1'bx};
            end
            spi_sclk_o <= 1'b1;
            repeat (HALF) @(posedge clock_i);
            spi_sclk_o <= 1'b0;
        end
        repeat (HALF) @(posedge clock_i);
        spi_sen_n_o <= 1'b1;
        // data line means nothing between frames
        spi_sdi_o <= ~frm[0];
        repeat (8) @(posedge clock_i);
    endtask
endmodule

// File: test/pdarc_top_tb.sv
// self-checking bench of the power-down, alignment and reference registers
// assumes pdarc_top, the spi host model and the bound checker
`timescale 1ns/1ps

`include "pdarc_defs.svh"

module pdarc_top_tb;
    typedef struct packed {
        logic [6:0]  addr;
        logic [7:0]  data;
        logic [2:0]  mode;
        logic        pin;
        logic        refpin;
        logic [12:0] outs;
    } pdarc_tb_row_t;

    logic          clock_i = 1'b0;
    logic          resetn_i = 1'b0;
    logic          pin = 1'b0;
    logic          refpin = 1'b0;
    logic [2:0]    mode = 3'h3;
    logic          sclk, sen_n, sdi, sdo, oe_n;
    logic          frame_clock, bclk, a1, a0, b1, b0, gpd, cbuf, ramp, bg, align, se;
    logic [1:0]    ropt;
    int            errors = 0;
    int            num_checks = 0;
    int            align_cnt = 0;
    pdarc_tb_row_t rows [12];
    wire [12:0]    outs_w = {frame_clock, bclk, a1, a0, b1, b0, gpd, cbuf, ramp, bg, ropt, se};

    always #12.5 clock_i = ~clock_i;
    always @(posedge clock_i) if (align === 1'b1) align_cnt <= align_cnt + 1;

    pdarc_top i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .spi_sclk_i(sclk),
        .spi_sen_n_i(sen_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_n_o(oe_n),
        .shared_align_powerdown_pin_i(pin), .reference_buffer_pin_i(refpin),
        .output_lane_mode_i(mode), .frame_clock_out_powerdown_o(frame_clock),
        .bit_clock_out_powerdown_o(bclk), .lane_a1_powerdown_o(a1), .lane_a0_powerdown_o(a0),
        .lane_b1_powerdown_o(b1), .lane_b0_powerdown_o(b0), .global_powerdown_o(gpd),
        .clock_buffer_powerdown_o(cbuf), .reference_amp_powerdown_o(ramp),
        .bandgap_powerdown_o(bg), .align_command_o(align), .reference_option_o(ropt),
        .single_ended_clock_select_o(se));
    pdarc_spi_host i_host (.clock_i(clock_i), .spi_sclk_o(sclk), .spi_sen_n_o(sen_n),
        .spi_sdi_o(sdi), .spi_sdo_i(sdo), .spi_sdo_oe_n_i(oe_n));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [12:0] got, input logic [12:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        i_host.xfer(1'b0, a, d, 16, dummy);
    endtask
    task automatic wr_cut(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] dummy;
        i_host.xfer(1'b0, a, d, 12, dummy);
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] got;
        i_host.xfer(1'b1, a, 8'h00, 16, got);
        check({5'h00, got}, {5'h00, exp}, "readback");
    endtask
    task automatic do_reset();
        @(posedge clock_i) resetn_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge clock_i);
    endtask
    task automatic align_step(input logic [7:0] cfg, input logic rise, input int n);
        int base;
        base = align_cnt;
        wr(`PDARC_OFS_ALIGN_REF_CFG, cfg);
        if (rise) begin
            @(posedge clock_i) pin <= 1'b1;
            repeat (10) @(posedge clock_i);
            pin <= 1'b0;
        end
        repeat (10) @(posedge clock_i);
        check(13'(align_cnt - base), 13'(n), "alignment pulses");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clock_i);
        errors++;
        $display("unexpected at %0t: run did not finish", $time);
        stop_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rows = '{'{7'h09, 8'h30, 3'h3, 1'h0, 1'h0, 13'h1800}, '{7'h09, 8'h0F, 3'h3, 1'h0, 1'h0, 13'h0780},
                 '{7'h09, 8'h00, 3'h4, 1'h0, 1'h0, 13'h0500}, '{7'h09, 8'h00, 3'h5, 1'h0, 1'h0, 13'h0580},
                 '{7'h08, 8'h03, 3'h3, 1'h0, 1'h0, 13'h0070}, '{7'h0D, 8'h0E, 3'h3, 1'h0, 1'h0, 13'h0048},
                 '{7'h08, 8'h02, 3'h3, 1'h0, 1'h0, 13'h0000}, '{7'h0E, 8'h0D, 3'h3, 1'h0, 1'h0, 13'h0025},
                 '{7'h0E, 8'h0A, 3'h3, 1'h0, 1'h0, 13'h0002}, '{7'h0E, 8'h07, 3'h3, 1'h0, 1'h0, 13'h0000},
                 '{7'h0E, 8'h00, 3'h3, 1'h1, 1'h1, 13'h004A}, '{7'h0E, 8'h80, 3'h3, 1'h1, 1'h0, 13'h0000}};
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        check(outs_w, 13'h0600, "outputs after reset");
        for (int i = 0; i < 12; i++) begin
            @(posedge clock_i);
            mode <= rows[i].mode;
            pin <= rows[i].pin;
            refpin <= rows[i].refpin;
            wr(rows[i].addr, rows[i].data);
            repeat (6) @(posedge clock_i);
            @(negedge clock_i);
            check(outs_w, rows[i].outs, "table row");
        end
        @(posedge clock_i) pin <= 1'b0;
        $display("test table done");
        rd_chk(`PDARC_OFS_LVDS_OUT_PD, 8'h00);
        rd_chk(`PDARC_OFS_GLOBAL_PD_MASK, 8'h0E);
        wr(7'h20, 8'hFF);
        rd_chk(7'h20, 8'h00);
        wr(`PDARC_OFS_GLOBAL_PD_MASK, 8'hFF);
        rd_chk(`PDARC_OFS_GLOBAL_PD_MASK, 8'h0E);
        // a frame cut after 12 bits must leave the register alone
        wr_cut(`PDARC_OFS_GLOBAL_PD_MASK, 8'h00);
        rd_chk(`PDARC_OFS_GLOBAL_PD_MASK, 8'h0E);
        $display("test readback done");
        do_reset();
        rd_chk(`PDARC_OFS_MAIN_POWER, 8'h02);
        rd_chk(`PDARC_OFS_LVDS_OUT_PD, 8'h0C);
        rd_chk(`PDARC_OFS_GLOBAL_PD_MASK, 8'h00);
        rd_chk(`PDARC_OFS_ALIGN_REF_CFG, 8'h00);
        $display("test reset values done");
        align_step(8'h20, 1'b0, 0);
        align_step(8'h60, 1'b0, 1);
        align_step(8'h60, 1'b0, 0);
        align_step(8'h20, 1'b0, 0);
        align_step(8'h60, 1'b0, 1);
        align_step(8'h00, 1'b0, 0);
        align_step(8'h40, 1'b0, 0);
        align_step(8'h80, 1'b1, 1);
        align_step(8'hA0, 1'b1, 0);
        align_step(8'h00, 1'b0, 0);
        $display("test alignment done");
        stop_test();
    end
endmodule
